// [common/scgpm_pkg.sv]
// Constants, register map and types for the synchronous clock generator
package scgpm_pkg;
	// ==========================================
	// Widths
	localparam int PRESC_W = 8;
	localparam int SEL_W = 3;
	localparam int NSRC = 4;
	localparam int NPB = 2;
	localparam int MOD_W = 32;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFF_MAIN_CTRL = 8'h00;
	localparam logic [7:0] OFF_CPU_SEL = 8'h04;
	localparam logic [7:0] OFF_HSB_SEL = 8'h08;
	localparam logic [7:0] OFF_PB0_SEL = 8'h0c;
	localparam logic [7:0] OFF_PB1_SEL = 8'h10;
	localparam logic [7:0] OFF_CPU_GATE = 8'h14;
	localparam logic [7:0] OFF_HSB_GATE = 8'h18;
	localparam logic [7:0] OFF_PB0_GATE = 8'h1c;
	localparam logic [7:0] OFF_PB1_GATE = 8'h20;
	localparam logic [7:0] OFF_IRQ_EN = 8'h24;
	localparam logic [7:0] OFF_IRQ_DIS = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h34;
	localparam logic [7:0] OFF_STATUS = 8'h38;
	// ==========================================
	// Field positions
	localparam int SEL_DIV_BIT = 7;
	localparam int SETTLED_BIT = 0;
	localparam int PM_GATE_BIT = 0;
	localparam int BRIDGE_GATE_BIT = 0;
	// ==========================================
	// Reset values and codes
	localparam logic [1:0] SRC_SYSTEM_RC_OSC = 2'h0;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
	localparam logic [MOD_W-1:0] GATE_RESET = 32'hffffffff;
	localparam logic [PRESC_W-1:0] PRESC_WRAP = 8'hff;
	localparam logic [2:0] SLEEP_IDLE = 3'h0;
	localparam logic [2:0] SLEEP_FROZEN = 3'h1;
	localparam logic [2:0] SLEEP_STANDBY = 3'h2;
	localparam logic [2:0] SLEEP_STOP = 3'h3;
	localparam logic [2:0] SLEEP_STATIC = 3'h5;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================
	// Sleep state
	typedef enum logic [1:0] {
		SCG_RUN = 2'b01,
		SCG_SLEEP = 2'b10
	} scgpm_slp_t;
endpackage

// [core/scgpm_core.sv]
// Synchronous clock generator of the power manager unit
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// What this block does
// - High-speed select ignores writes, mirrors CPU select
// - Bus interface clock on at reset, sticky off
// - Main clock from system RC after reset
// - Eight-bit prescaler, undivided by default
// - CPU clock main over 2^(sel+1) when enabled
// - Each peripheral bus divides by 2^(sel+1)
// - Peripheral bus never faster than CPU, auto-adjusted
// - High-speed bus divides same as CPU
// - Settled flag low until new divide applied
// - Settled rise sets status, masked raises request
// - Enable write of one sets mask bit
// - Module clocks on after reset, gate bits
// - Gated module stops, registers inaccessible
// - Separate gate bit per domain
// - Own or bridge clock gated locks gates
// - Sleep halts chosen domains regardless of gates
// - Interrupt wakes, restarting halted domains
// - Six sleep indices, each deeper than the last except 4, same as 3
module scgpm_core (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Clock source ticks, one pulse per source clock edge
	input wire logic [scgpm_pkg::NSRC-1:0] src_tick,
	// Sleep instruction and wake request
	input wire logic sleep_req,
	input wire logic [2:0] sleep_mode,
	input wire logic wake_irq,
	// Domain clock ticks
	output logic cpu_clk_tick,
	output logic hsb_clk_tick,
	output logic [scgpm_pkg::NPB-1:0] pb_clk_tick,
	// Module clock enables
	output logic [scgpm_pkg::MOD_W-1:0] cpu_mod_clk_en,
	output logic [scgpm_pkg::MOD_W-1:0] hsb_mod_clk_en,
	output logic [scgpm_pkg::MOD_W-1:0] pb0_mod_clk_en,
	output logic [scgpm_pkg::MOD_W-1:0] pb1_mod_clk_en,
	// Status
	output logic manager_bus_if_clock,
	output logic sleep_active,
	output logic sources_stop,
	output logic rc_osc_stop,
	output logic irq
);
	// ==========================================
	// Helpers
	function automatic logic div_tick(input logic [7:0] cnt, input logic en, input logic [2:0] sel);
		logic [7:0] low;
		low = 8'(({1'b0, 8'hff} << (sel + 4'h1)) >> 0);
		return !en || (&(cnt | low));
	endfunction

	// Bus clock may not run faster than CPU clock
	function automatic logic [3:0] clamp_pb(input logic [3:0] pb, input logic [3:0] cpu);
		logic [3:0] r;
		r = pb;
		if (cpu[3] && (!pb[3] || pb[2:0] < cpu[2:0])) begin
			r = cpu;
		end
		return r;
	endfunction

	// ==========================================
	// Register state
	logic [1:0] main_src_reg;
	logic [3:0] cpu_sel_reg;
	logic [3:0] pb_sel_reg [scgpm_pkg::NPB];
	logic [3:0] cpu_act_reg;
	logic [3:0] pb_act_reg [scgpm_pkg::NPB];
	logic pend_reg;
	logic settled_reg;
	logic irq_stat_reg;
	logic irq_mask_reg;
	logic [scgpm_pkg::MOD_W-1:0] cpu_gate_reg, hsb_gate_reg, pb0_gate_reg, pb1_gate_reg;
	logic [7:0] presc_reg;
	scgpm_pkg::scgpm_slp_t slp_reg;
	logic [2:0] slp_idx_reg;

	// ==========================================
	// AXI4-Lite write path
	logic [7:0] aw_addr_reg;
	logic aw_full_reg, w_full_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_wr;
	logic bus_on;
	logic gates_locked;
	logic wr_ok;

	assign bus_on = pb0_gate_reg[scgpm_pkg::PM_GATE_BIT];
	assign gates_locked = !bus_on || !hsb_gate_reg[scgpm_pkg::BRIDGE_GATE_BIT];
	assign do_wr = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign wr_ok = do_wr && bus_on && w_strb_reg[0];

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= scgpm_pkg::RESP_OKAY;
		end else begin
			s_axi_awready <= !aw_full_reg && !s_axi_awready && s_axi_awvalid;
			s_axi_wready <= !w_full_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= bus_on ? scgpm_pkg::RESP_OKAY : scgpm_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// AXI4-Lite read path
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		case (s_axi_araddr)
			scgpm_pkg::OFF_MAIN_CTRL: rd_mux = {30'h0, main_src_reg};
			scgpm_pkg::OFF_CPU_SEL: rd_mux = {24'h0, cpu_sel_reg[3], 4'h0, cpu_sel_reg[2:0]};
			scgpm_pkg::OFF_HSB_SEL: rd_mux = {24'h0, cpu_sel_reg[3], 4'h0, cpu_sel_reg[2:0]};
			scgpm_pkg::OFF_PB0_SEL: rd_mux = {24'h0, pb_sel_reg[0][3], 4'h0, pb_sel_reg[0][2:0]};
			scgpm_pkg::OFF_PB1_SEL: rd_mux = {24'h0, pb_sel_reg[1][3], 4'h0, pb_sel_reg[1][2:0]};
			scgpm_pkg::OFF_CPU_GATE: rd_mux = cpu_gate_reg;
			scgpm_pkg::OFF_HSB_GATE: rd_mux = hsb_gate_reg;
			scgpm_pkg::OFF_PB0_GATE: rd_mux = pb0_gate_reg;
			scgpm_pkg::OFF_PB1_GATE: rd_mux = pb1_gate_reg;
			scgpm_pkg::OFF_IRQ_MASK: rd_mux = {31'h0, irq_mask_reg};
			scgpm_pkg::OFF_IRQ_STAT: rd_mux = {31'h0, irq_stat_reg};
			scgpm_pkg::OFF_STATUS: rd_mux = {31'h0, settled_reg};
			default: rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= scgpm_pkg::RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= bus_on ? rd_mux : 32'h00000000;
				s_axi_rresp <= bus_on ? scgpm_pkg::RESP_OKAY : scgpm_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ==========================================
	// Write decode
	logic wr_main, wr_cpu, wr_pb0, wr_pb1, wr_sel;
	logic [3:0] wsel;

	assign wr_main = wr_ok && aw_addr_reg == scgpm_pkg::OFF_MAIN_CTRL;
	assign wr_cpu = wr_ok && aw_addr_reg == scgpm_pkg::OFF_CPU_SEL;
	assign wr_pb0 = wr_ok && aw_addr_reg == scgpm_pkg::OFF_PB0_SEL;
	assign wr_pb1 = wr_ok && aw_addr_reg == scgpm_pkg::OFF_PB1_SEL;
	assign wr_sel = wr_cpu || wr_pb0 || wr_pb1;
	assign wsel = {w_data_reg[scgpm_pkg::SEL_DIV_BIT], w_data_reg[2:0]};

	// ==========================================
	// Main source and select registers
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			main_src_reg <= scgpm_pkg::SRC_SYSTEM_RC_OSC;
			cpu_sel_reg <= {1'b0, scgpm_pkg::SEL_RESET};
			pb_sel_reg[0] <= {1'b0, scgpm_pkg::SEL_RESET};
			pb_sel_reg[1] <= {1'b0, scgpm_pkg::SEL_RESET};
		end else begin
			if (wr_main) begin
				main_src_reg <= w_data_reg[1:0];
			end
			// High-speed select write has no effect
			if (wr_cpu) begin
				cpu_sel_reg <= wsel;
			end
			if (wr_pb0) begin
				pb_sel_reg[0] <= wsel;
			end
			if (wr_pb1) begin
				pb_sel_reg[1] <= wsel;
			end
		end
	end

	// ==========================================
	// Prescaler and setting hand-over
	logic main_tick;
	logic wrap;

	assign main_tick = src_tick[main_src_reg];
	assign wrap = main_tick && presc_reg == scgpm_pkg::PRESC_WRAP;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			presc_reg <= 8'h00;
		end else if (main_tick) begin
			presc_reg <= presc_reg + 8'h01;
		end
	end

	// Applying only at full wrap keeps every old and new period whole
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cpu_act_reg <= {1'b0, scgpm_pkg::SEL_RESET};
			pb_act_reg[0] <= {1'b0, scgpm_pkg::SEL_RESET};
			pb_act_reg[1] <= {1'b0, scgpm_pkg::SEL_RESET};
			pend_reg <= 1'b0;
		end else if (wr_sel) begin
			pend_reg <= 1'b1;
		end else if (pend_reg && wrap) begin
			cpu_act_reg <= cpu_sel_reg;
			pb_act_reg[0] <= clamp_pb(pb_sel_reg[0], cpu_sel_reg);
			pb_act_reg[1] <= clamp_pb(pb_sel_reg[1], cpu_sel_reg);
			pend_reg <= 1'b0;
		end
	end

	// ==========================================
	// Settled flag and interrupt
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			settled_reg <= 1'b1;
		end else begin
			settled_reg <= !pend_reg && !wr_sel;
		end
	end

	logic settled_rise;
	assign settled_rise = !settled_reg && !pend_reg && !wr_sel;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_stat_reg <= 1'b0;
		end else if (settled_rise) begin
			// Set on rise, wins over clear
			irq_stat_reg <= 1'b1;
		end else if (wr_ok && aw_addr_reg == scgpm_pkg::OFF_IRQ_CLR && w_data_reg[scgpm_pkg::SETTLED_BIT]) begin
			irq_stat_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_mask_reg <= 1'b0;
		end else if (wr_ok && aw_addr_reg == scgpm_pkg::OFF_IRQ_EN && w_data_reg[scgpm_pkg::SETTLED_BIT]) begin
			irq_mask_reg <= 1'b1;
		end else if (wr_ok && aw_addr_reg == scgpm_pkg::OFF_IRQ_DIS && w_data_reg[scgpm_pkg::SETTLED_BIT]) begin
			irq_mask_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_stat_reg && irq_mask_reg;
		end
	end

	// ==========================================
	// Module clock gates
	logic gate_wr;
	assign gate_wr = wr_ok && !gates_locked;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cpu_gate_reg <= scgpm_pkg::GATE_RESET;
			hsb_gate_reg <= scgpm_pkg::GATE_RESET;
			pb0_gate_reg <= scgpm_pkg::GATE_RESET;
			pb1_gate_reg <= scgpm_pkg::GATE_RESET;
		end else if (gate_wr) begin
			case (aw_addr_reg)
				scgpm_pkg::OFF_CPU_GATE: cpu_gate_reg <= w_data_reg;
				scgpm_pkg::OFF_HSB_GATE: hsb_gate_reg <= w_data_reg;
				scgpm_pkg::OFF_PB0_GATE: pb0_gate_reg <= w_data_reg;
				scgpm_pkg::OFF_PB1_GATE: pb1_gate_reg <= w_data_reg;
				default: cpu_gate_reg <= cpu_gate_reg;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			manager_bus_if_clock <= 1'b1;
		end else begin
			manager_bus_if_clock <= bus_on;
		end
	end

	// ==========================================
	// Sleep control
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			slp_reg <= scgpm_pkg::SCG_RUN;
			slp_idx_reg <= scgpm_pkg::SLEEP_IDLE;
		end else begin
			case (slp_reg)
				scgpm_pkg::SCG_RUN: begin
					if (sleep_req && sleep_mode <= scgpm_pkg::SLEEP_STATIC) begin
						slp_reg <= scgpm_pkg::SCG_SLEEP;
						slp_idx_reg <= sleep_mode;
					end
				end
				scgpm_pkg::SCG_SLEEP: begin
					if (wake_irq || irq) begin
						slp_reg <= scgpm_pkg::SCG_RUN;
					end
				end
				default: slp_reg <= scgpm_pkg::SCG_RUN;
			endcase
		end
	end

	logic asleep, halt_cpu, halt_hsb, halt_pb;
	assign asleep = slp_reg == scgpm_pkg::SCG_SLEEP;
	assign halt_cpu = asleep;
	assign halt_hsb = asleep && slp_idx_reg >= scgpm_pkg::SLEEP_FROZEN;
	assign halt_pb = asleep && slp_idx_reg >= scgpm_pkg::SLEEP_STANDBY;

	// ==========================================
	// Registered domain outputs
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cpu_clk_tick <= 1'b0;
			hsb_clk_tick <= 1'b0;
			pb_clk_tick <= '0;
			sleep_active <= 1'b0;
			sources_stop <= 1'b0;
			rc_osc_stop <= 1'b0;
		end else begin
			cpu_clk_tick <= main_tick && !halt_cpu && div_tick(presc_reg, cpu_act_reg[3], cpu_act_reg[2:0]);
			hsb_clk_tick <= main_tick && !halt_hsb && div_tick(presc_reg, cpu_act_reg[3], cpu_act_reg[2:0]);
			for (int i = 0; i < scgpm_pkg::NPB; i++) begin
				pb_clk_tick[i] <= main_tick && !halt_pb && div_tick(presc_reg, pb_act_reg[i][3], pb_act_reg[i][2:0]);
			end
			sleep_active <= asleep;
			sources_stop <= asleep && slp_idx_reg >= scgpm_pkg::SLEEP_STOP;
			rc_osc_stop <= asleep && slp_idx_reg == scgpm_pkg::SLEEP_STATIC;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			cpu_mod_clk_en <= scgpm_pkg::GATE_RESET;
			hsb_mod_clk_en <= scgpm_pkg::GATE_RESET;
			pb0_mod_clk_en <= scgpm_pkg::GATE_RESET;
			pb1_mod_clk_en <= scgpm_pkg::GATE_RESET;
		end else begin
			cpu_mod_clk_en <= halt_cpu ? '0 : cpu_gate_reg;
			hsb_mod_clk_en <= halt_hsb ? '0 : hsb_gate_reg;
			pb0_mod_clk_en <= halt_pb ? '0 : pb0_gate_reg;
			pb1_mod_clk_en <= halt_pb ? '0 : pb1_gate_reg;
		end
	end
endmodule // scgpm_core

// [tb/scgpm_checker.sv]
// Port checker for the synchronous clock generator
`timescale 1ns/1ps
module scgpm_checker (
	// Clock, reset and write response
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	// Sleep
	input wire logic sleep_req,
	input wire logic [2:0] sleep_mode,
	input wire logic wake_irq,
	input wire logic sleep_active,
	input wire logic sources_stop,
	input wire logic rc_osc_stop,
	// Clocks and status
	input wire logic cpu_clk_tick,
	input wire logic hsb_clk_tick,
	input wire logic [scgpm_pkg::NPB-1:0] pb_clk_tick,
	input wire logic [scgpm_pkg::MOD_W-1:0] cpu_mod_clk_en,
	input wire logic [scgpm_pkg::MOD_W-1:0] pb0_mod_clk_en,
	input wire logic manager_bus_if_clock,
	input wire logic irq
);
	logic lock_q, lock_qq, run_q, run_qq, awake;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (srst);
	// ==========
	// History of lock and sleep
	always_ff @(posedge ref_clk) begin
		lock_q <= !srst && !manager_bus_if_clock;
		lock_qq <= !srst && lock_q;
		run_q <= srst || !sleep_active;
		run_qq <= srst || run_q;
	end
	// Ticks compared only away from sleep edges, where halting may skew them
	assign awake = !sleep_active && run_q && run_qq;
	// ==========
	// Assertions
	reset_levels_a: assert property ($fell(srst) |->
		cpu_mod_clk_en == 32'hffffffff && manager_bus_if_clock && !irq) else $error("Levels wrong after reset");
	bus_clk_sticky_a: assert property (!manager_bus_if_clock |=> !manager_bus_if_clock)
		else $error("Bus clock back without reset");
	locked_resp_a: assert property ($rose(s_axi_bvalid) && lock_qq |-> s_axi_bresp == scgpm_pkg::RESP_SLVERR)
		else $error("Write accepted while locked");
	hsb_with_cpu_a: assert property (awake |-> hsb_clk_tick == cpu_clk_tick)
		else $error("Fast bus tick differs from CPU tick");
	pb_not_faster_a: assert property (awake && (|pb_clk_tick) |-> cpu_clk_tick)
		else $error("Peripheral tick without CPU tick");
	// Indices above static are refused, so only legal ones must enter
	sleep_entry_a: assert property (sleep_req && sleep_mode <= scgpm_pkg::SLEEP_STATIC && !sleep_active |->
		##[1:2] sleep_active) else $error("Sleep not entered");
	cpu_halted_a: assert property (sleep_active |-> ##[0:1] cpu_mod_clk_en == 32'h0)
		else $error("CPU modules clocked in sleep");
	wake_exit_a: assert property (sleep_active && (wake_irq || irq) |-> ##[1:3] !sleep_active)
		else $error("Sleep not left on interrupt");
	stop_depth_a: assert property (sources_stop |-> sleep_active && pb0_mod_clk_en == 32'h0)
		else $error("Sources stopped in shallow sleep");
	static_depth_a: assert property (rc_osc_stop |-> sources_stop)
		else $error("RC stopped before sources");
	cover property ($rose(irq));
	cover property ($rose(sleep_active));
	cover property ($fell(manager_bus_if_clock));
	cover property ($rose(rc_osc_stop));
endmodule // scgpm_checker

bind scgpm_core scgpm_checker u_chk (.ref_clk(ref_clk), .srst(srst), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .sleep_req(sleep_req), .sleep_mode(sleep_mode), .wake_irq(wake_irq),
	.sleep_active(sleep_active),
	.sources_stop(sources_stop), .rc_osc_stop(rc_osc_stop), .cpu_clk_tick(cpu_clk_tick),
	.hsb_clk_tick(hsb_clk_tick), .pb_clk_tick(pb_clk_tick), .cpu_mod_clk_en(cpu_mod_clk_en),
	.pb0_mod_clk_en(pb0_mod_clk_en), .manager_bus_if_clock(manager_bus_if_clock), .irq(irq));

// [tb/scgpm_partner.sv]
// Far side: clock sources and clocked domains counting their edges
`timescale 1ns/1ps
module scgpm_partner (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// Sources, periods 1, 2, 4 and 8 cycles
	output logic [scgpm_pkg::NSRC-1:0] src_tick,
	// Domain clocks in, edge counts out
	input wire logic cnt_clr,
	input wire logic cpu_clk_tick,
	input wire logic hsb_clk_tick,
	input wire logic [scgpm_pkg::NPB-1:0] pb_clk_tick,
	output logic [15:0] cpu_cnt,
	output logic [15:0] hsb_cnt,
	output logic [15:0] pb0_cnt,
	output logic [15:0] pb1_cnt
);
	logic [2:0] phase_reg;
	// ==========
	// Sources
	// Sources always ready
	always_ff @(posedge ref_clk) begin
		phase_reg <= srst ? 3'h0 : phase_reg + 3'h1;
	end
	assign src_tick = {&phase_reg, &phase_reg[1:0], phase_reg[0], 1'b1};
	// ==========
	// Edge counters, so rates are judged over whole windows
	always_ff @(posedge ref_clk) begin
		if (srst || cnt_clr) begin
			cpu_cnt <= 16'h0;
			hsb_cnt <= 16'h0;
			pb0_cnt <= 16'h0;
			pb1_cnt <= 16'h0;
		end else begin
			cpu_cnt <= cpu_cnt + 16'(cpu_clk_tick);
			hsb_cnt <= hsb_cnt + 16'(hsb_clk_tick);
			pb0_cnt <= pb0_cnt + 16'(pb_clk_tick[0]);
			pb1_cnt <= pb1_cnt + 16'(pb_clk_tick[1]);
		end
	end
endmodule // scgpm_partner

// [tb/sync_clock_generator_pm_tb.sv]
// Self-checking bench for the synchronous clock generator
`timescale 1ns/1ps
module sync_clock_generator_pm_tb;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] awa = 8'h0, ara = 8'h0;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, slp = 1'b0, wake = 1'b0, clr = 1'b0;
	logic [2:0] smode = 3'h0;
	logic awr, wrdy, bv, arr, rv, cpu_t, hsb_t, busclk, sact, sstop, rcstop, irq;
	logic [1:0] bresp, rresp, pbt, r;
	logic [31:0] rdat, cen, hen, p0en, p1en, d;
	logic [3:0] srct;
	logic [15:0] c_cpu, c_hsb, c_pb0, c_pb1;
	int bad_count = 0, checked = 0;
	always #5 ref_clk = ~ref_clk;
	scgpm_core DUT (.ref_clk(ref_clk), .srst(srst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .src_tick(srct),
		.sleep_req(slp), .sleep_mode(smode), .wake_irq(wake), .cpu_clk_tick(cpu_t), .hsb_clk_tick(hsb_t),
		.pb_clk_tick(pbt), .cpu_mod_clk_en(cen), .hsb_mod_clk_en(hen), .pb0_mod_clk_en(p0en),
		.pb1_mod_clk_en(p1en), .manager_bus_if_clock(busclk), .sleep_active(sact), .sources_stop(sstop),
		.rc_osc_stop(rcstop), .irq(irq));
	scgpm_partner FAR (.ref_clk(ref_clk), .srst(srst), .src_tick(srct), .cnt_clr(clr), .cpu_clk_tick(cpu_t),
		.hsb_clk_tick(hsb_t), .pb_clk_tick(pbt), .cpu_cnt(c_cpu), .hsb_cnt(c_hsb), .pb0_cnt(c_pb0),
		.pb1_cnt(c_pb1));
	// ==========
	// Reporting
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic guard(input int n);
		if (n > 300) begin
			chk(32'h0, 32'h1);
			final_report();
		end
	endtask
	// ==========
	// Bus cycles, each starting just after an edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		int n = 0;
		@(posedge ref_clk);
		awa <= a;
		awv <= 1'b1;
		wd <= v;
		wv <= 1'b1;
		br <= 1'b1;
		while (bv !== 1'b1) begin
			@(posedge ref_clk);
			n++;
			guard(n);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrdy === 1'b1) wv <= 1'b0;
		end
		r = bresp;
		br <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		int n = 0;
		@(posedge ref_clk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		while (rv !== 1'b1) begin
			@(posedge ref_clk);
			n++;
			guard(n);
			if (arr === 1'b1) arv <= 1'b0;
		end
		d = rdat;
		r = rresp;
		rr <= 1'b0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
	endtask
	task automatic settle();
		int n = 0;
		d = 32'h0;
		while (d[scgpm_pkg::SETTLED_BIT] !== 1'b1) begin
			n++;
			guard(n);
			rd(scgpm_pkg::OFF_STATUS);
		end
	endtask
	// Edges of each domain over a 64-cycle window
	task automatic count(input logic [15:0] ec, input logic [15:0] e0, input logic [15:0] e1);
		@(posedge ref_clk);
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		repeat (65) @(posedge ref_clk);
		chk({16'h0, c_cpu}, {16'h0, ec});
		chk({16'h0, c_hsb}, {16'h0, ec});
		chk({16'h0, c_pb0}, {16'h0, e0});
		chk({16'h0, c_pb1}, {16'h0, e1});
	endtask
	task automatic do_reset();
		srst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
	endtask
	// ==========
	// Main sequence
	initial begin
		do_reset();
		chk(cen, 32'hffffffff);
		chk({31'h0, busclk}, 32'h1);
		rc(scgpm_pkg::OFF_MAIN_CTRL, 32'h0);
		rc(scgpm_pkg::OFF_CPU_SEL, 32'h0);
		rc(scgpm_pkg::OFF_STATUS, 32'h1);
		for (int i = 0; i < 4; i++) rc(scgpm_pkg::OFF_CPU_GATE + 8'(4 * i), 32'hffffffff);
		rc(8'h3c, 32'h0);
		count(16'd64, 16'd64, 16'd64);
		wr(scgpm_pkg::OFF_MAIN_CTRL, 32'h1);
		rc(scgpm_pkg::OFF_MAIN_CTRL, 32'h1);
		repeat (300) @(posedge ref_clk);
		count(16'd32, 16'd32, 16'd32);
		wr(scgpm_pkg::OFF_MAIN_CTRL, 32'h0);
		repeat (300) @(posedge ref_clk);
		settle();
		wr(scgpm_pkg::OFF_CPU_SEL, 32'h81);
		rc(scgpm_pkg::OFF_STATUS, 32'h0);
		settle();
		wr(scgpm_pkg::OFF_HSB_SEL, 32'h0);
		rc(scgpm_pkg::OFF_HSB_SEL, 32'h81);
		settle();
		wr(scgpm_pkg::OFF_PB0_SEL, 32'h82);
		settle();
		wr(scgpm_pkg::OFF_PB1_SEL, 32'h80);
		settle();
		count(16'd16, 16'd8, 16'd16);
		wr(scgpm_pkg::OFF_IRQ_CLR, 32'h1);
		wr(scgpm_pkg::OFF_IRQ_EN, 32'h1);
		rc(scgpm_pkg::OFF_IRQ_MASK, 32'h1);
		chk({31'h0, irq}, 32'h0);
		wr(scgpm_pkg::OFF_CPU_SEL, 32'h80);
		settle();
		@(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		rc(scgpm_pkg::OFF_IRQ_STAT, 32'h1);
		count(16'd32, 16'd8, 16'd32);
		wr(scgpm_pkg::OFF_IRQ_CLR, 32'h1);
		wr(scgpm_pkg::OFF_IRQ_DIS, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		wr(scgpm_pkg::OFF_CPU_GATE, 32'hfffffffe);
		wr(scgpm_pkg::OFF_HSB_GATE, 32'hfffffffd);
		wr(scgpm_pkg::OFF_PB1_GATE, 32'h7fffffff);
		repeat (2) @(posedge ref_clk);
		chk(cen, 32'hfffffffe);
		chk(hen, 32'hfffffffd);
		chk(p1en, 32'h7fffffff);
		chk(p0en, 32'hffffffff);
		for (int m = 0; m < 6; m++) begin
			smode <= 3'(m);
			slp <= 1'b1;
			@(posedge ref_clk);
			slp <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk(cen, 32'h0);
			chk(hen, m > 0 ? 32'h0 : 32'hfffffffd);
			chk(p1en, m > 1 ? 32'h0 : 32'h7fffffff);
			chk({29'h0, sact, sstop, rcstop}, {29'h0, 1'b1, m > 2, m > 4});
			wake <= 1'b1;
			@(posedge ref_clk);
			wake <= 1'b0;
			repeat (3) @(posedge ref_clk);
			chk({31'h0, sact}, 32'h0);
			chk(cen, 32'hfffffffe);
		end
		// Index beyond static must be refused
		smode <= 3'h7;
		slp <= 1'b1;
		@(posedge ref_clk);
		slp <= 1'b0;
		repeat (3) @(posedge ref_clk);
		chk({31'h0, sact}, 32'h0);
		chk(cen, 32'hfffffffe);
		wr(scgpm_pkg::OFF_HSB_GATE, 32'hffffffff);
		repeat (2) @(posedge ref_clk);
		chk(hen, 32'hffffffff);
		wr(scgpm_pkg::OFF_PB0_GATE, 32'hfffffffe);
		repeat (2) @(posedge ref_clk);
		chk({31'h0, busclk}, 32'h0);
		wr(scgpm_pkg::OFF_CPU_GATE, 32'hffffffff);
		chk({30'h0, r}, {30'h0, scgpm_pkg::RESP_SLVERR});
		rc(scgpm_pkg::OFF_CPU_SEL, 32'h0);
		chk({30'h0, r}, {30'h0, scgpm_pkg::RESP_SLVERR});
		chk(cen, 32'hfffffffe);
		do_reset();
		chk({31'h0, busclk}, 32'h1);
		chk(cen, 32'hffffffff);
		final_report();
	end
endmodule // sync_clock_generator_pm_tb
